// [bench/odt_ctl_model.sv]
`timescale 1ns/100ps
// ----------------------------------------
// Controlling logic on the timer pins
// ----------------------------------------
module odt_ctl_model (
    input wire logic pclk,
    output logic execution_input,
    output logic timer_reset_in
);
    // Both pins idle low until the bench commands a level
    initial
    begin
        execution_input = 1'b0;
        timer_reset_in = 1'b0;
    end

    // Levels change just after an edge, so the sync flops never see a race
    task drive(input logic x, input logic r);
        @(posedge pclk);
        execution_input <= x;
        timer_reset_in <= r;
    endtask
endmodule

// [bench/on_off_delay_timer_bench.sv]
`timescale 1ns/100ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin err_total++; $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module on_off_delay_timer_bench;
    import odt_pkg::*;
    // Short prescale keeps the 1 s unit affordable
    localparam int CYC = 4;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic [31:0] rd;
    logic pready;
    logic pslverr;
    logic er;
    logic execution_input;
    logic timer_reset_in;
    logic timer_out;
    int err_total = 0;
    int compares = 0;
    int cyc = 0;
    int t0;
    int p;

    // ----------------------------------------
    // Clock, cycle count and instances
    // ----------------------------------------
    always #50 pclk = ~pclk;
    always @(posedge pclk) cyc <= cyc + 1;

    odt_timer #(.CYC_MS(CYC)) odt_timer_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .execution_input(execution_input), .timer_reset_in(timer_reset_in), .timer_out(timer_out));
    odt_ctl_model odt_ctl_model_inst (.pclk(pclk), .execution_input(execution_input),
        .timer_reset_in(timer_reset_in));

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task end_sim();
        $display("compares=%0d err_total=%0d", compares, err_total);
        if (err_total == 0 && compares > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // One APB transfer; request held until pready is seen high
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do
        begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 16);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        `CHK(pready, 1'b1)
        if (k >= 16)
            end_sim();
    endtask

    task wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task rdc(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        `CHK(rd, e)
    endtask

    // Bounded wait for the output to reach a level
    task wt(input logic v, input int mx);
        int k;
        k = 0;
        while (timer_out !== v)
        begin
            @(posedge pclk);
            k++;
            if (k > mx)
            begin
                `CHK(timer_out, v)
                end_sim();
            end
        end
    endtask

    // Elapsed cycles since t0 must lie in a window
    task win(input int lo, input int hi);
        `CHK((cyc - t0) >= lo && (cyc - t0) <= hi, 1'b1)
    endtask

    task pin(input logic x, input logic r);
        odt_ctl_model_inst.drive(x, r);
        t0 = cyc;
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial
    begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        rdc(OFS_CTRL, 32'h0);
        rdc(OFS_STATUS, 32'h2);
        apb(1'b0, 8'h40, 32'h0);
        `CHK(er, 1'b1)
        wr(OFS_SLOT_BASE, 32'hC6);
        rdc(OFS_SLOT_BASE, 32'hC7C6);
        wr(OFS_ON_PRESET, 32'h1FFFF);
        rdc(OFS_ON_PRESET, 32'hFFFF);
        // Every tick unit: preset 2 needs at least one whole tick period
        wr(OFS_ON_PRESET, 32'h2);
        wr(OFS_OFF_PRESET, 32'h0);
        for (int u = 0; u < 4; u++)
        begin
            wr(OFS_CTRL, u);
            p = CYC * (10 ** u);
            pin(1'b1, 1'b0);
            wt(1'b1, 2 * p + 10);
            win(p, 2 * p + 8);
            pin(1'b0, 1'b0);
            wt(1'b0, 20);
        end
        // Plain on then off delay, with a re-rise during off counting
        wr(OFS_CTRL, 32'h0);
        wr(OFS_ON_PRESET, 32'h3);
        wr(OFS_OFF_PRESET, 32'h5);
        pin(1'b1, 1'b0);
        wt(1'b1, 30);
        win(8, 20);
        rdc(OFS_ON_ELAPSED, 32'h3);
        pin(1'b0, 1'b0);
        repeat (7) @(posedge pclk);
        `CHK(timer_out, 1'b1)
        pin(1'b1, 1'b0);
        repeat (6) @(posedge pclk);
        rdc(OFS_OFF_ELAPSED, 32'h0);
        `CHK(timer_out, 1'b1)
        pin(1'b0, 1'b0);
        wt(1'b0, 40);
        win(16, 28);
        // Presets rewritten while counting
        wr(OFS_ON_PRESET, 32'h4);
        pin(1'b1, 1'b0);
        wr(OFS_ON_PRESET, 32'h8);
        wr(OFS_OFF_PRESET, 32'h2);
        wt(1'b1, 60);
        rdc(OFS_ON_ELAPSED, 32'h8);
        pin(1'b0, 1'b0);
        wt(1'b0, 40);
        win(4, 16);
        pin(1'b1, 1'b0);
        wt(1'b1, 60);
        pin(1'b0, 1'b0);
        wr(OFS_OFF_PRESET, 32'h6);
        wr(OFS_ON_PRESET, 32'h1);
        wt(1'b0, 60);
        win(20, 32);
        pin(1'b1, 1'b0);
        wt(1'b1, 20);
        win(0, 12);
        wr(OFS_ON_PRESET, 32'd100);
        wr(OFS_OFF_PRESET, 32'd100);
        pin(1'b0, 1'b0);
        wt(1'b0, 500);
        pin(1'b1, 1'b0);
        repeat (12) @(posedge pclk);
        wr(OFS_ON_PRESET, 32'h1);
        wt(1'b1, 6);
        pin(1'b0, 1'b0);
        repeat (12) @(posedge pclk);
        wr(OFS_OFF_PRESET, 32'h1);
        wt(1'b0, 6);
        // Presets taken from data words 3 and 5
        wr(8'h2C, 32'h3);
        wr(8'h34, 32'h5);
        wr(OFS_SRC_INDEX, 32'h0503);
        wr(OFS_ON_PRESET, 32'd100);
        wr(OFS_OFF_PRESET, 32'd100);
        wr(OFS_CTRL, 32'hC);
        pin(1'b1, 1'b0);
        wt(1'b1, 30);
        win(8, 20);
        pin(1'b0, 1'b0);
        wt(1'b0, 40);
        win(16, 28);
        // Timer reset pin: ignored while unconnected, dominant once connected
        wr(OFS_CTRL, 32'h0);
        wr(OFS_ON_PRESET, 32'h0);
        wr(OFS_OFF_PRESET, 32'h0);
        pin(1'b1, 1'b1);
        wt(1'b1, 10);
        wr(OFS_CTRL, 32'h10);
        wt(1'b0, 8);
        repeat (20) @(posedge pclk);
        `CHK(timer_out, 1'b0)
        rdc(OFS_ON_ELAPSED, 32'h0);
        rdc(OFS_OFF_ELAPSED, 32'h0);
        pin(1'b1, 1'b0);
        repeat (20) @(posedge pclk);
        `CHK(timer_out, 1'b0)
        rdc(OFS_STATUS, 32'h2);
        pin(1'b0, 1'b0);
        pin(1'b1, 1'b0);
        wt(1'b1, 10);
        // Bus reset mid-run drops run-time presets
        wr(OFS_ON_PRESET, 32'h7);
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rdc(OFS_ON_PRESET, {16'h0, RST_ON_PRESET});
        `CHK(timer_out, 1'b0)
        repeat (10) @(posedge pclk);
        `CHK(timer_out, 1'b0)
        rdc(OFS_STATUS, 32'h2);
        end_sim();
    end
endmodule

// [common/odt_pkg.sv]
// Contract
// [R1] Rising execution input, output off, no reset: on-delay count starts incrementing.
// [R2] Output turns on when on-delay count reaches on-delay preset.
// [R3] Execution input falls: off-delay count runs; output off when it reaches preset.
// [R4] Execution input back on during off-delay counting clears off-delay count to zero.
// [R5] Reset overrides execution input and holds the output off.
// [R6] An unconnected reset input is treated as permanently inactive.
// [R7] Both presets are unsigned 16-bit values, 0 to 65,535.
// [R8] One tick unit for both presets: 1 sec, 100 ms, 10 ms, 1 ms.
// [R9] Each preset comes from a constant or indirectly from a numbered data register.
// [R10] An instance takes two consecutive slots: base for on-delay, next for off-delay.
// [R11] Software picks base slot at most 198 (98 small variant), not reused.
// [R12] On-delay preset raised above count while on-counting: keep counting to it.
// [R13] On-delay preset at or below count while on-counting: output on at once.
// [R14] Off-delay preset change during on-delay counting takes effect immediately.
// [R15] Off-delay preset raised above count while off-counting: keep counting to it.
// [R16] Off-delay preset at or below count while off-counting: output off at once.
// [R17] On-delay preset change during off-delay counting takes effect immediately.
// [R18] Run-time presets are volatile; reset restores the program presets.
// [R19] Elapsed counts advance one per tick and stop once equal to preset.
// [R20] Reset holds both counts at zero; afterwards idle, output off, awaiting rise.
package odt_pkg;

    // ----------------------------------------
    // Timebase
    // ----------------------------------------
    localparam int CLK_PERIOD_NS = 100;
    localparam int MS_TICK_NS = 1000000;
    localparam int CYC_PER_MS = MS_TICK_NS / CLK_PERIOD_NS;
    localparam logic [3:0] DECADE_LAST = 4'h9;
    // Edges after bus reset before the pin edge detector is trusted
    localparam logic [1:0] SETTLE_LAST = 2'h3;

    // Tick unit codes
    localparam logic [1:0] UNIT_1MS = 2'h0;
    localparam logic [1:0] UNIT_10MS = 2'h1;
    localparam logic [1:0] UNIT_100MS = 2'h2;
    localparam logic [1:0] UNIT_1S = 2'h3;

    // ----------------------------------------
    // Register map (byte offsets)
    // ----------------------------------------
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_ON_PRESET = 8'h04;
    localparam logic [7:0] OFS_OFF_PRESET = 8'h08;
    localparam logic [7:0] OFS_SRC_INDEX = 8'h0C;
    localparam logic [7:0] OFS_SLOT_BASE = 8'h10;
    localparam logic [7:0] OFS_STATUS = 8'h14;
    localparam logic [7:0] OFS_ON_ELAPSED = 8'h18;
    localparam logic [7:0] OFS_OFF_ELAPSED = 8'h1C;
    localparam logic [2:0] DATA_REGION = 3'h1;
    localparam int DATA_WORDS = 8;

    // Field positions
    localparam int CTRL_UNIT_LSB = 0;
    localparam int CTRL_ON_IND_BIT = 2;
    localparam int CTRL_OFF_IND_BIT = 3;
    localparam int CTRL_RST_CONN_BIT = 4;
    localparam int IDX_OFF_LSB = 8;
    localparam int SLOT_NEXT_LSB = 8;

    // Values after reset; program presets restored at power-up
    localparam logic [15:0] RST_ON_PRESET = 16'h0000;
    localparam logic [15:0] RST_OFF_PRESET = 16'h0000;
    localparam logic [7:0] RST_SLOT_BASE = 8'h00;
    localparam logic [15:0] RST_DATA = 16'h0000;

    // ----------------------------------------
    // Types
    // ----------------------------------------
    typedef struct packed {
        logic rst_conn;
        logic off_ind;
        logic on_ind;
        logic [1:0] unit;
    } odt_cfg_s;

    localparam odt_cfg_s RST_CFG = '{rst_conn: 1'b0, off_ind: 1'b0, on_ind: 1'b0, unit: UNIT_1MS};

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_ON_CNT = 4'b0010,
        ST_ON_HOLD = 4'b0100,
        ST_OFF_CNT = 4'b1000
    } odt_state_e;

endpackage

// [rtl/odt_sync2.sv]
`timescale 1ns/100ps
module odt_sync2 #(
    parameter int WIDTH = 1
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    import odt_pkg::*;

    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] sync_ff;
    logic [WIDTH-1:0] nxt_meta;
    logic [WIDTH-1:0] nxt_sync;

    // First stage feeds only the second stage
    always_comb
    begin
        nxt_meta = async_in;
        nxt_sync = meta_ff;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            meta_ff <= '0;
            sync_ff <= '0;
        end
        else
        begin
            meta_ff <= nxt_meta;
            sync_ff <= nxt_sync;
        end
    end

    assign sync_out = sync_ff;
endmodule

// [rtl/odt_tick.sv]
`timescale 1ns/100ps
module odt_tick #(
    parameter int CYC_MS = odt_pkg::CYC_PER_MS
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [1:0] unit_sel,
    output logic tick
);
    import odt_pkg::*;

    logic [15:0] pre_ff;
    logic [3:0] d10_ff;
    logic [3:0] d100_ff;
    logic [3:0] d1s_ff;
    logic tick_ff;
    logic [15:0] nxt_pre;
    logic [3:0] nxt_d10;
    logic [3:0] nxt_d100;
    logic [3:0] nxt_d1s;
    logic nxt_tick;
    logic ms_end;
    logic e10;
    logic e100;
    logic e1s;

    // Millisecond prescaler, then three decades; one counter chain serves all units
    always_comb
    begin
        ms_end = (pre_ff == 16'(CYC_MS - 1));
        e10 = ms_end && (d10_ff == DECADE_LAST);
        e100 = e10 && (d100_ff == DECADE_LAST);
        e1s = e100 && (d1s_ff == DECADE_LAST);
        nxt_pre = ms_end ? 16'h0000 : pre_ff + 16'h0001;
        nxt_d10 = ms_end ? (e10 ? 4'h0 : d10_ff + 4'h1) : d10_ff;
        nxt_d100 = e10 ? (e100 ? 4'h0 : d100_ff + 4'h1) : d100_ff;
        nxt_d1s = e100 ? (e1s ? 4'h0 : d1s_ff + 4'h1) : d1s_ff;
        unique case (unit_sel) // R8
            UNIT_1MS: nxt_tick = ms_end;
            UNIT_10MS: nxt_tick = e10;
            UNIT_100MS: nxt_tick = e100;
            UNIT_1S: nxt_tick = e1s;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pre_ff <= 16'h0000;
            d10_ff <= 4'h0;
            d100_ff <= 4'h0;
            d1s_ff <= 4'h0;
            tick_ff <= 1'b0;
        end
        else
        begin
            pre_ff <= nxt_pre;
            d10_ff <= nxt_d10;
            d100_ff <= nxt_d100;
            d1s_ff <= nxt_d1s;
            tick_ff <= nxt_tick;
        end
    end

    assign tick = tick_ff;

    // Millisecond tick never fires on two adjacent cycles
    chk_tick_single: assert property (@(posedge pclk) disable iff (!presetn) // R8
        (unit_sel == UNIT_1MS) && tick_ff |=> !tick_ff)
        else $error("tick pulse longer than one cycle");
endmodule

// [rtl/odt_timer.sv]
// Our own choices: the placing of the registers and register access over APB.
`timescale 1ns/100ps
module odt_timer #(
    parameter int CYC_MS = odt_pkg::CYC_PER_MS
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic execution_input,
    input wire logic timer_reset_in,
    output logic timer_out
);
    import odt_pkg::*;

    // ----------------------------------------
    // Declarations
    // ----------------------------------------
    odt_cfg_s cfg_ff;
    odt_cfg_s nxt_cfg;
    logic [15:0] on_preset_ff;
    logic [15:0] nxt_on_preset;
    logic [15:0] off_preset_ff;
    logic [15:0] nxt_off_preset;
    logic [2:0] on_idx_ff;
    logic [2:0] nxt_on_idx;
    logic [2:0] off_idx_ff;
    logic [2:0] nxt_off_idx;
    logic [7:0] slot_base_ff;
    logic [7:0] nxt_slot_base;
    logic [15:0] data_ff [DATA_WORDS];
    logic [15:0] nxt_data [DATA_WORDS];
    logic [31:0] prdata_ff;
    logic [31:0] nxt_prdata;
    logic pready_ff;
    logic nxt_pready;
    logic pslverr_ff;
    logic nxt_pslverr;
    logic setup;
    logic wr_en;
    logic hit;
    logic [31:0] rd_val;

    odt_state_e state_ff;
    odt_state_e nxt_state;
    logic [15:0] on_cnt_ff;
    logic [15:0] nxt_on_cnt;
    logic [15:0] off_cnt_ff;
    logic [15:0] nxt_off_cnt;
    logic out_ff;
    logic nxt_out;
    logic exec_prev_ff;
    logic nxt_exec_prev;
    logic [1:0] settle_ff;
    logic [1:0] nxt_settle;
    logic [1:0] pins_sync;
    logic exec;
    logic rst_act;
    logic exec_rise;
    logic tick;
    logic [15:0] on_pre;
    logic [15:0] off_pre;

    // ----------------------------------------
    // Pin synchronisers and timebase
    // ----------------------------------------
    odt_sync2 #(
        .WIDTH(2)
    ) u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .async_in({timer_reset_in, execution_input}),
        .sync_out(pins_sync)
    );

    odt_tick #(
        .CYC_MS(CYC_MS)
    ) u_tick (
        .pclk(pclk),
        .presetn(presetn),
        .unit_sel(cfg_ff.unit),
        .tick(tick)
    );

    // A reset pin marked unconnected never acts
    assign exec = pins_sync[0];
    assign rst_act = cfg_ff.rst_conn && pins_sync[1]; // R6
    assign exec_rise = exec && !exec_prev_ff && (settle_ff == SETTLE_LAST); // R20 sync fill is no rise

    // Presets are read live every cycle, so edits apply without delay
    assign on_pre = cfg_ff.on_ind ? data_ff[on_idx_ff] : on_preset_ff; // R9 R14 R17
    assign off_pre = cfg_ff.off_ind ? data_ff[off_idx_ff] : off_preset_ff; // R9 R14 R17

    // ----------------------------------------
    // APB slave
    // ----------------------------------------
    // Read data is latched in setup so every bus output is a flop
    always_comb
    begin
        setup = psel && !penable;
        wr_en = psel && penable && pready_ff && pwrite;
        hit = (paddr[1:0] == 2'h0);
        rd_val = 32'h0000_0000;
        unique case (paddr)
            OFS_CTRL: rd_val = {27'h0, cfg_ff};
            OFS_ON_PRESET: rd_val = {16'h0, on_preset_ff};
            OFS_OFF_PRESET: rd_val = {16'h0, off_preset_ff};
            OFS_SRC_INDEX: rd_val = {21'h0, off_idx_ff, 5'h0, on_idx_ff};
            OFS_SLOT_BASE: rd_val = {16'h0, 8'(slot_base_ff + 8'h01), slot_base_ff}; // R10
            OFS_STATUS: rd_val = {27'h0, state_ff, out_ff};
            OFS_ON_ELAPSED: rd_val = {16'h0, on_cnt_ff};
            OFS_OFF_ELAPSED: rd_val = {16'h0, off_cnt_ff};
            default:
            begin
                if (paddr[7:5] == DATA_REGION)
                    rd_val = {16'h0, data_ff[paddr[4:2]]};
                else
                    hit = 1'b0;
            end
        endcase
        nxt_pready = setup;
        nxt_prdata = (setup && !pwrite && hit) ? rd_val : 32'h0000_0000;
        nxt_pslverr = setup && !hit;
    end

    // Writable registers; the status and elapsed words ignore writes
    always_comb
    begin
        nxt_cfg = cfg_ff;
        nxt_on_preset = on_preset_ff;
        nxt_off_preset = off_preset_ff;
        nxt_on_idx = on_idx_ff;
        nxt_off_idx = off_idx_ff;
        nxt_slot_base = slot_base_ff;
        nxt_data = data_ff;
        if (wr_en && hit)
        begin
            unique case (paddr)
                OFS_CTRL: nxt_cfg = odt_cfg_s'(pwdata[4:0]);
                OFS_ON_PRESET: nxt_on_preset = pwdata[15:0]; // R7
                OFS_OFF_PRESET: nxt_off_preset = pwdata[15:0]; // R7
                OFS_SRC_INDEX:
                begin
                    nxt_on_idx = pwdata[2:0];
                    nxt_off_idx = pwdata[IDX_OFF_LSB +: 3];
                end
                OFS_SLOT_BASE: nxt_slot_base = pwdata[7:0]; // R10
                default:
                begin
                    if (paddr[7:5] == DATA_REGION)
                        nxt_data[paddr[4:2]] = pwdata[15:0];
                end
            endcase
        end
    end

    // Presets sit in volatile flops and return to program values on reset
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cfg_ff <= RST_CFG;
            on_preset_ff <= RST_ON_PRESET; // R18
            off_preset_ff <= RST_OFF_PRESET; // R18
            on_idx_ff <= 3'h0;
            off_idx_ff <= 3'h0;
            slot_base_ff <= RST_SLOT_BASE;
            for (int i = 0; i < DATA_WORDS; i++)
                data_ff[i] <= RST_DATA;
            prdata_ff <= 32'h0000_0000;
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
        end
        else
        begin
            cfg_ff <= nxt_cfg;
            on_preset_ff <= nxt_on_preset;
            off_preset_ff <= nxt_off_preset;
            on_idx_ff <= nxt_on_idx;
            off_idx_ff <= nxt_off_idx;
            slot_base_ff <= nxt_slot_base;
            data_ff <= nxt_data;
            prdata_ff <= nxt_prdata;
            pready_ff <= nxt_pready;
            pslverr_ff <= nxt_pslverr;
        end
    end

    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;

    // ----------------------------------------
    // On/off-delay sequencer
    // ----------------------------------------
    // Comparisons use >= so a preset lowered under the count acts at once
    always_comb
    begin
        nxt_state = state_ff;
        nxt_on_cnt = on_cnt_ff;
        nxt_off_cnt = off_cnt_ff;
        nxt_out = out_ff;
        nxt_exec_prev = exec;
        nxt_settle = (settle_ff == SETTLE_LAST) ? settle_ff : settle_ff + 2'h1;
        if (rst_act)
        begin
            nxt_state = ST_IDLE; // R5 R20
            nxt_on_cnt = 16'h0000; // R20
            nxt_off_cnt = 16'h0000; // R20
            nxt_out = 1'b0; // R5
        end
        else
        begin
            unique case (state_ff)
                ST_IDLE:
                begin
                    if (exec_rise)
                    begin
                        nxt_state = ST_ON_CNT; // R1
                        nxt_on_cnt = 16'h0000;
                        nxt_off_cnt = 16'h0000;
                    end
                end
                ST_ON_CNT:
                begin
                    if (!exec)
                    begin
                        // Input dropped before the delay ran out
                        nxt_state = ST_IDLE;
                        nxt_on_cnt = 16'h0000;
                    end
                    else if (on_cnt_ff >= on_pre)
                    begin
                        nxt_state = ST_ON_HOLD; // R2 R13
                        nxt_out = 1'b1; // R2 R13
                    end
                    else if (tick)
                        nxt_on_cnt = on_cnt_ff + 16'h0001; // R1 R12 R19
                end
                ST_ON_HOLD:
                begin
                    if (!exec)
                    begin
                        nxt_state = ST_OFF_CNT; // R3
                        nxt_off_cnt = 16'h0000;
                    end
                end
                ST_OFF_CNT:
                begin
                    if (exec)
                    begin
                        nxt_state = ST_ON_HOLD;
                        nxt_off_cnt = 16'h0000; // R4
                    end
                    else if (off_cnt_ff >= off_pre)
                    begin
                        nxt_state = ST_IDLE; // R3 R16
                        nxt_out = 1'b0; // R3 R16
                    end
                    else if (tick)
                        nxt_off_cnt = off_cnt_ff + 16'h0001; // R3 R15 R19
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_ff <= ST_IDLE;
            on_cnt_ff <= 16'h0000;
            off_cnt_ff <= 16'h0000;
            out_ff <= 1'b0;
            exec_prev_ff <= 1'b0;
            settle_ff <= 2'h0;
        end
        else
        begin
            state_ff <= nxt_state;
            on_cnt_ff <= nxt_on_cnt;
            off_cnt_ff <= nxt_off_cnt;
            out_ff <= nxt_out;
            exec_prev_ff <= nxt_exec_prev;
            settle_ff <= nxt_settle;
        end
    end

    assign timer_out = out_ff;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence s_fall_in_hold;
        (state_ff == ST_ON_HOLD) && !exec && !rst_act;
    endsequence

    sequence s_off_entry;
        (state_ff == ST_OFF_CNT) && out_ff && (off_cnt_ff == 16'h0000);
    endsequence

    chk_rst_out_off: assert property (rst_act |=> !out_ff) // R5
        else $error("output on while reset active");

    chk_rst_cnt_zero: assert property (rst_act |=> (on_cnt_ff == 16'h0000) && (off_cnt_ff == 16'h0000)) // R20
        else $error("counts not zero under reset");

    chk_on_start: assert property ((state_ff == ST_IDLE) && exec_rise && !rst_act |=> state_ff == ST_ON_CNT) // R1
        else $error("on-delay count did not start");

    chk_settle_quiet: assert property ((settle_ff != SETTLE_LAST) |=> state_ff == ST_IDLE) // R20
        else $error("timer left idle while pin samples settle");

    chk_on_reach: assert property ( // R2
        (state_ff == ST_ON_CNT) && exec && !rst_act && (on_cnt_ff >= on_pre) |=> out_ff)
        else $error("output not on at on-delay preset");

    chk_on_step: assert property ( // R19
        (state_ff == ST_ON_CNT) && exec && tick && !rst_act && (on_cnt_ff < on_pre)
        |=> on_cnt_ff == $past(on_cnt_ff) + 16'h0001 && !out_ff)
        else $error("on-delay count step wrong");

    chk_off_enter: assert property (s_fall_in_hold |=> s_off_entry) // R3
        else $error("off-delay counting not entered with output held");

    chk_off_clear: assert property ((state_ff == ST_OFF_CNT) && exec && !rst_act |=> off_cnt_ff == 16'h0000) // R4
        else $error("off-delay count not cleared");

    chk_off_reach: assert property ( // R16
        (state_ff == ST_OFF_CNT) && !exec && !rst_act && (off_cnt_ff >= off_pre) |=> !out_ff)
        else $error("output not off at off-delay preset");

    chk_off_hold: assert property ( // R15
        (state_ff == ST_OFF_CNT) && !exec && !rst_act && (off_cnt_ff < off_pre) |=> out_ff)
        else $error("output dropped before off-delay preset");
endmodule
